//--- general_output_pin_config_bench.sv
// self-checking bench for the output pin configuration bank
// assumes gopc_bank, gopc_host and gopc_monitor compiled before it
`timescale 1ns/10ps
`default_nettype none
module general_output_pin_config_bench;
   import gopc_pkg::*;
   logic         clk = 1'b0, nrst = 1'b0, chip_ready_low = 1'b1, clr = 1'b0;
   logic [7:0]   chip_status = 8'h0F, status_data = 8'h00, fifo_data = 8'h00, rd, pops_ff = 8'h00;
   logic [63:0]  pin_sources = 64'h0000_0000_0000_0000;
   logic [13:0]  strobes, seen_ff = 14'h0000;
   logic [5:0]   status_addr;
   logic         spi_miso, spi_miso_oe_n, fifo_rd, pin_drive_strength;
   gopc_spi_in_t spi_in;
   gopc_pin_t    pin_a, pin_b;
   int           fail_count = 0, tests_run = 0;
   gopc_bank u_dut (.clk(clk), .nrst(nrst), .spi_in(spi_in), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
      .chip_status(chip_status), .status_data(status_data), .status_addr(status_addr), .fifo_data(fifo_data),
      .fifo_rd(fifo_rd), .strobes(strobes), .chip_ready_low(chip_ready_low), .pin_sources(pin_sources),
      .pin_a(pin_a), .pin_b(pin_b), .pin_drive_strength(pin_drive_strength));
   gopc_host u_host (.clk(clk), .spi_in(spi_in), .miso(spi_miso), .miso_oe_n(spi_miso_oe_n));
   always #2.5 clk = ~clk;
   // sticky capture of strobes and fifo pops
   always @(posedge clk) begin
      seen_ff <= clr ? 14'h0000 : seen_ff | strobes;
      pops_ff <= clr ? 8'h00 : pops_ff + {7'h00, fifo_rd};
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic clear_seen;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [7:0] v);
      u_host.xfer({2'h2, a}, 8'h00, 2, v);
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
      u_host.xfer({2'h0, a}, v, 2, rd);
   endtask
   // defaults after reset, ready routed to pin b
   task automatic t_reset;
      check({15'h0000, pin_drive_strength}, 16'h0000);
      check({14'h0000, pin_a}, 16'h0001);
      chip_ready_low = 1'b0;
      repeat (3) @(negedge clk);
      check({14'h0000, pin_b}, 16'h0000);
      rd_reg(GOPC_ADDR_PIN_B, rd);
      check({8'h00, rd}, 16'h0029);
      rd_reg(GOPC_ADDR_PIN_A, rd);
      check({8'h00, rd}, 16'h002E);
   endtask
   // pin a inverted on source 5, high drive
   task automatic t_pin_a;
      pin_sources[5] = 1'b1;
      wr_reg(GOPC_ADDR_PIN_A, 8'hC5);
      check({14'h0000, pin_a}, 16'h0000);
      check({15'h0000, pin_drive_strength}, 16'h0001);
      pin_sources[5] = 1'b0;
      repeat (3) @(negedge clk);
      check({14'h0000, pin_a}, 16'h0002);
   endtask
   // pin b bit 7 dropped, inversion of source 63
   task automatic t_pin_b;
      wr_reg(GOPC_ADDR_PIN_B, 8'hFF);
      rd_reg(GOPC_ADDR_PIN_B, rd);
      check({8'h00, rd}, 16'h007F);
      check({14'h0000, pin_b}, 16'h0002);
   endtask
   // status, fifo and unmapped space
   task automatic t_status;
      status_data = 8'h5A;
      fifo_data = 8'hC3;
      rd_reg(6'h35, rd);
      check({8'h00, rd}, 16'h005A);
      check({10'h000, status_addr}, 16'h0035);
      clear_seen();
      rd_reg(GOPC_ADDR_RX_FIFO, rd);
      check({8'h00, rd}, 16'h00C3);
      check({8'h00, pops_ff}, 16'h0001);
      wr_reg(6'h10, 8'hA5);
      rd_reg(6'h10, rd);
      check({8'h00, rd}, 16'h0000);
   endtask
   // every named strobe, 0x3F gives none, sleep keeps config
   task automatic t_strobes;
      int codes [9] = '{2, 3, 4, 6, 9, 10, 13, 15, 0};
      for (int k = 0; k < 9; k++) begin
         clear_seen();
         u_host.xfer({2'h0, 6'h30 + 6'(codes[k])}, 8'h00, 1, rd);
         check({2'h0, seen_ff}, codes[k] < 14 ? 16'h0001 << codes[k] : 16'h0000);
         if (codes[k] == 9) begin
            rd_reg(GOPC_ADDR_PIN_A, rd);
            check({8'h00, rd}, 16'h00C5);
         end
      end
      rd_reg(GOPC_ADDR_PIN_A, rd);
      check({8'h00, rd}, 16'h002E);
   endtask
   // burst access across both configs, then a second reset in mid-run
   task automatic t_burst;
      u_host.xfer({2'h1, GOPC_ADDR_PIN_B}, 8'h45, 3, rd);
      check({12'h000, pin_b, pin_a}, 16'h0008);
      wr_reg(GOPC_ADDR_PIN_A, 8'h9C);
      check({15'h0000, pin_drive_strength}, 16'h0001);
      u_host.xfer({2'h3, GOPC_ADDR_PIN_B}, 8'h00, 3, rd);
      check({8'h00, rd}, 16'h009C);
      u_host.xfer({2'h2, GOPC_ADDR_PIN_B}, 8'h00, 3, rd);
      check({8'h00, rd}, 16'h0045);
      nrst = 1'b0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      check({15'h0000, pin_drive_strength}, 16'h0000);
      rd_reg(GOPC_ADDR_PIN_B, rd);
      check({8'h00, rd}, 16'h0029);
      rd_reg(GOPC_ADDR_PIN_A, rd);
      check({8'h00, rd}, 16'h002E);
   endtask
   initial begin
      repeat (50000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      t_reset();
      t_pin_a();
      t_pin_b();
      t_status();
      t_strobes();
      t_burst();
      give_verdict();
   end
endmodule // general_output_pin_config_bench
`default_nettype wire

//--- gopc_bank.sv
// spi slave with output pin configuration registers and upper map decode
// assumes sclk at most clk/8, spi mode 0, msb first, data sources on clk
// Behaviour
// [RQ1] Bit 6 of each pin config inverts its pin: one means active low.
// [RQ2] Pin b select field resets to 41, routing the chip-ready-low signal.
// [RQ3] Pin a select field resets to 46, leaving pin a three-stated.
// [RQ4] Bit 7 of pin a config sets drive strength for all pins, resets zero.
// [RQ5] Bit 7 of pin b config is unused and reads zero.
// [RQ6] Pin configs keep their contents through sleep; only reset reloads them.
// [RQ7] Upper addresses: writes are strobes, reads are status; 0x3F reaches rx fifo.
// [RQ8] Config changes reach the pins within a few clocks, without glitches.
`timescale 1ns/10ps
`default_nettype none
module gopc_bank (
   input  wire logic                  clk,                 // 200 mhz system clock
   input  wire logic                  nrst,                // async reset, active low
   input  wire gopc_pkg::gopc_spi_in_t spi_in,             // spi pins, asynchronous
   output logic                       spi_miso,            // serial data out
   output logic                       spi_miso_oe_n,       // miso enable, low drives
   input  wire logic [7:0]            chip_status,         // status byte sent on header and write bytes
   input  wire logic [7:0]            status_data,         // status register contents
   output logic [5:0]                 status_addr,         // status register selected
   input  wire logic [7:0]            fifo_data,           // rx fifo head byte
   output logic                       fifo_rd,             // rx fifo pop pulse
   output logic [13:0]                strobes,             // command strobe pulses
   input  wire logic                  chip_ready_low,      // low when chip ready
   input  wire logic [63:0]           pin_sources,         // other selectable signals
   output gopc_pkg::gopc_pin_t        pin_a,               // first output pin
   output gopc_pkg::gopc_pin_t        pin_b,               // second output pin
   output logic                       pin_drive_strength   // one for high drive
);
   import gopc_pkg::*;

   gopc_state_t s_ff;
   gopc_state_t nxt_s;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_active;
   logic        cs_fall;
   logic [7:0]  rx_byte;
   logic [7:0]  rd_byte;
   logic [63:0] src_vec;

   localparam gopc_state_t GOPC_STATE_RST = '{
      sclk_sy:     3'h0,
      csn_sy:      3'h7,
      mosi_sy:     2'h0,
      bitcnt:      3'h0,
      hdr_done:    1'b0,
      wr:          1'b0,
      burst:       1'b0,
      addr:        6'h00,
      shin:        8'h00,
      shout:       8'h00,
      miso:        1'b0,
      miso_oe_n:   1'b1,
      cfg_a:       GOPC_RST_PIN_A,
      cfg_b:       GOPC_RST_PIN_B[6:0],
      strobes:     14'h0000,
      status_addr: 6'h00,
      fifo_rd:     1'b0
   };

   // edges taken from second and third synchroniser stages only
   assign sclk_rise = s_ff.sclk_sy[1] & ~s_ff.sclk_sy[2];
   assign sclk_fall = ~s_ff.sclk_sy[1] & s_ff.sclk_sy[2];
   assign cs_active = ~s_ff.csn_sy[1];
   assign cs_fall   = s_ff.csn_sy[2] & ~s_ff.csn_sy[1];
   assign rx_byte   = {s_ff.shin[6:0], s_ff.mosi_sy[1]};

   // read data for the current address
   always_comb begin
      rd_byte = 8'h00;
      if (s_ff.addr == GOPC_ADDR_PIN_B) begin
         rd_byte = {1'b0, s_ff.cfg_b};  // RQ5
      end else if (s_ff.addr == GOPC_ADDR_PIN_A) begin
         rd_byte = s_ff.cfg_a;
      end else if (s_ff.addr == GOPC_ADDR_RX_FIFO) begin
         rd_byte = fifo_data;  // RQ7
      end else if (s_ff.addr >= GOPC_ADDR_CMD_LO) begin
         rd_byte = status_data;  // RQ7
      end
   end

   // spi framing, register writes and upper map decode
   always_comb begin
      nxt_s         = s_ff;
      nxt_s.sclk_sy = {s_ff.sclk_sy[1:0], spi_in.sclk};
      nxt_s.csn_sy  = {s_ff.csn_sy[1:0], spi_in.csn};
      nxt_s.mosi_sy = {s_ff.mosi_sy[0], spi_in.mosi};
      nxt_s.strobes = '0;
      nxt_s.fifo_rd = 1'b0;
      if (!cs_active) begin
         // deselected: miso floats, framing restarts
         nxt_s.miso_oe_n = 1'b1;
         nxt_s.hdr_done  = 1'b0;
         nxt_s.bitcnt    = 3'h0;
      end else if (cs_fall) begin
         // first status bit must stand before the first rising edge
         nxt_s.miso_oe_n = 1'b0;
         nxt_s.hdr_done  = 1'b0;
         nxt_s.bitcnt    = 3'h0;
         nxt_s.miso      = chip_status[7];
         nxt_s.shout     = {chip_status[6:0], 1'b0};
      end else if (sclk_rise) begin
         nxt_s.shin   = rx_byte;
         nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
         if (s_ff.bitcnt == 3'h7) begin
            if (!s_ff.hdr_done) begin
               // header byte: direction, burst, address
               nxt_s.hdr_done    = 1'b1;
               nxt_s.wr          = ~rx_byte[GOPC_HDR_RD_BIT];
               nxt_s.burst       = rx_byte[GOPC_HDR_BURST_BIT];
               nxt_s.addr        = rx_byte[5:0];
               nxt_s.status_addr = rx_byte[5:0];
               if (!rx_byte[GOPC_HDR_RD_BIT] && rx_byte[5:0] >= GOPC_ADDR_CMD_LO
                   && rx_byte[5:0] <= GOPC_ADDR_CMD_HI) begin
                  nxt_s.strobes[4'(rx_byte[5:0] - GOPC_ADDR_CMD_LO)] = 1'b1;  // RQ7
               end
               if (rx_byte[GOPC_HDR_RD_BIT] && rx_byte[5:0] == GOPC_ADDR_RX_FIFO) begin
                  nxt_s.fifo_rd = 1'b1;  // RQ7
               end
            end else begin
               // data byte
               if (s_ff.wr && s_ff.addr == GOPC_ADDR_PIN_A) begin
                  nxt_s.cfg_a = rx_byte;  // RQ4
               end
               if (s_ff.wr && s_ff.addr == GOPC_ADDR_PIN_B) begin
                  nxt_s.cfg_b = rx_byte[6:0];  // RQ5
               end
               if (s_ff.burst && s_ff.addr < GOPC_ADDR_CMD_LO) begin
                  nxt_s.addr = s_ff.addr + 6'h01;
               end
               if (s_ff.burst && !s_ff.wr && s_ff.addr == GOPC_ADDR_RX_FIFO) begin
                  nxt_s.fifo_rd = 1'b1;  // RQ7
               end
            end
         end
      end else if (sclk_fall) begin
         // new byte loads on the first falling edge after a byte boundary
         if (s_ff.bitcnt == 3'h0) begin
            if (s_ff.hdr_done && !s_ff.wr) begin
               nxt_s.miso  = rd_byte[7];
               nxt_s.shout = {rd_byte[6:0], 1'b0};
            end else begin
               nxt_s.miso  = chip_status[7];
               nxt_s.shout = {chip_status[6:0], 1'b0};
            end
         end else begin
            nxt_s.miso  = s_ff.shout[7];
            nxt_s.shout = {s_ff.shout[6:0], 1'b0};
         end
      end
      // software reset strobe reloads the pin configs; sleep does not
      if (s_ff.strobes[GOPC_STB_RESET]) begin
         nxt_s.cfg_a = GOPC_RST_PIN_A;  // RQ6
         nxt_s.cfg_b = GOPC_RST_PIN_B[6:0];
      end
   end

   // state register; configs change only through nrst, spi writes and the reset strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= GOPC_STATE_RST;  // RQ2 RQ3 RQ4 RQ6
      end else begin
         s_ff <= nxt_s;
      end
   end

   // selectable signals with the chip-ready code wired in
   always_comb begin
      src_vec                      = pin_sources;
      src_vec[GOPC_SEL_CHIP_READY] = chip_ready_low;  // RQ2
   end

   // first output pin
   gopc_pin_drv #(.SEL_W(GOPC_SEL_W)) u_pin_a (
      .clk     (clk),
      .nrst    (nrst),
      .sel     (s_ff.cfg_a[GOPC_SEL_MSB:0]),  // RQ3
      .invert  (s_ff.cfg_a[GOPC_INV_BIT]),   // RQ1
      .sources (src_vec),
      .pin     (pin_a)
   );

   // second output pin
   gopc_pin_drv #(.SEL_W(GOPC_SEL_W)) u_pin_b (
      .clk     (clk),
      .nrst    (nrst),
      .sel     (s_ff.cfg_b[GOPC_SEL_MSB:0]),  // RQ2
      .invert  (s_ff.cfg_b[GOPC_INV_BIT]),   // RQ1
      .sources (src_vec),
      .pin     (pin_b)
   );

   // outputs straight from the state register
   assign spi_miso           = s_ff.miso;
   assign spi_miso_oe_n      = s_ff.miso_oe_n;
   assign status_addr        = s_ff.status_addr;
   assign fifo_rd            = s_ff.fifo_rd;
   assign strobes            = s_ff.strobes;
   assign pin_drive_strength = s_ff.cfg_a[GOPC_DS_BIT];  // RQ4
endmodule // gopc_bank
`default_nettype wire

//--- gopc_host.sv
// host microcontroller model on the spi port
// assumes 200 mhz clk; sclk half period five clocks, mode 0
`timescale 1ns/10ps
`default_nettype none
module gopc_host (
   input  wire logic                  clk,       // system clock
   output var gopc_pkg::gopc_spi_in_t spi_in,    // pins to device
   input  wire logic                  miso,      // device serial out
   input  wire logic                  miso_oe_n  // low while driven
);
   import gopc_pkg::*;
   initial spi_in = 3'h2;
   // one frame of nb bytes, msb first; rd keeps the last byte
   task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat, input int nb, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {hdr, dat};
      rd = 8'h00;
      @(negedge clk);
      spi_in.csn = 1'b0;
      for (int i = 0; i < 8 * nb; i++) begin
         repeat (5) @(negedge clk);
         spi_in.sclk = 1'b0;
         spi_in.mosi = sh[15];
         sh = sh << 1;
         repeat (5) @(negedge clk);
         spi_in.sclk = 1'b1;
         rd = {rd[6:0], miso_oe_n ? 1'bx : miso};
      end
      repeat (5) @(negedge clk);
      spi_in.sclk = 1'b0;
      repeat (5) @(negedge clk);
      spi_in.csn = 1'b1;
      spi_in.mosi = ~spi_in.mosi; // released line shows no stale bit
      repeat (8) @(negedge clk);
   endtask
endmodule // gopc_host
`default_nettype wire

//--- gopc_monitor.sv
// checker on the ports of the output pin configuration bank
// assumes one clock domain; bound to gopc_bank below
`timescale 1ns/10ps
`default_nettype none
module gopc_monitor (
   input wire logic                   clk,                // system clock
   input wire logic                   nrst,               // async reset
   input wire gopc_pkg::gopc_spi_in_t spi_in,             // spi pins
   input wire logic                   spi_miso_oe_n,      // miso enable
   input wire logic [5:0]             status_addr,        // selected status
   input wire logic                   fifo_rd,            // fifo pop
   input wire logic [13:0]            strobes,            // strobe pulses
   input wire logic                   chip_ready_low,     // ready input
   input wire gopc_pkg::gopc_pin_t    pin_a,              // first pin
   input wire gopc_pkg::gopc_pin_t    pin_b,              // second pin
   input wire logic                   pin_drive_strength  // drive strength
);
   import gopc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // release of reset, and a quiet bus
   sequence s_release;
      $rose(nrst);
   endsequence
   sequence s_idle;
      spi_in.csn [*5];
   endsequence
   // pin defaults, polarity and three-state
   a_rst_pin_a: assert property (s_release |-> pin_a.oe_n && !pin_a.level && !pin_drive_strength)
      else $error("pin a not at default after reset");
   a_rst_pin_b: assert property (s_release |-> ##[1:2] (!pin_b.oe_n && pin_b.level == chip_ready_low))
      else $error("pin b does not show ready after reset");
   a_hiz_low: assert property (pin_a.oe_n |-> !pin_a.level)
      else $error("three-stated pin drives a level");
   // upper map decode, miso enable and config hold
   a_strobe_pulse: assert property (|strobes |=> strobes == 14'h0000)
      else $error("strobe longer than one cycle");
   a_strobe_addr: assert property (|strobes |-> strobes == 14'h0001 << (status_addr - 6'h30))
      else $error("strobe does not match address");
   a_fifo_addr: assert property (fifo_rd |-> status_addr == 6'h3F ##1 !fifo_rd)
      else $error("fifo pop off its address");
   a_miso_off: assert property (s_idle |-> spi_miso_oe_n)
      else $error("miso driven while deselected");
   a_miso_on: assert property (!spi_in.csn [*5] |-> !spi_miso_oe_n)
      else $error("miso not driven while selected");
   a_cfg_hold: assert property (s_idle |-> $stable(pin_drive_strength))
      else $error("config changed with bus quiet");
endmodule // gopc_monitor
bind gopc_bank gopc_monitor u_mon (.clk(clk), .nrst(nrst), .spi_in(spi_in), .spi_miso_oe_n(spi_miso_oe_n),
   .status_addr(status_addr), .fifo_rd(fifo_rd), .strobes(strobes), .chip_ready_low(chip_ready_low),
   .pin_a(pin_a), .pin_b(pin_b), .pin_drive_strength(pin_drive_strength));
`default_nettype wire

//--- gopc_pin_drv.sv
// one general output pin: selects a source, applies polarity, registers it
// assumes sources come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module gopc_pin_drv #(
   parameter int SEL_W = 6
) (
   input  wire logic                 clk,      // system clock
   input  wire logic                 nrst,     // async reset, active low
   input  wire logic [SEL_W-1:0]     sel,      // signal select code
   input  wire logic                 invert,   // one makes the pin active low
   input  wire logic [2**SEL_W-1:0]  sources,  // selectable signals
   output gopc_pkg::gopc_pin_t       pin       // registered pin drive
);
   import gopc_pkg::*;

   gopc_pin_t s_ff;
   gopc_pin_t nxt_s;

   // elaboration check on select width
   if (SEL_W != GOPC_SEL_W) begin : g_bad_width
      $error("gopc_pin_drv: select width must match code width");
   end

   // pick source, apply polarity, float on the three-state code
   always_comb begin
      nxt_s       = s_ff;
      nxt_s.oe_n  = (sel == GOPC_SEL_HIZ);
      nxt_s.level = nxt_s.oe_n ? 1'b0 : (sources[sel] ^ invert);  // RQ1
   end

   // one register stage keeps the change clean of glitches
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '{level: 1'b0, oe_n: 1'b1};
      end else begin
         s_ff <= nxt_s;  // RQ8
      end
   end

   assign pin = s_ff;
endmodule // gopc_pin_drv
`default_nettype wire

//--- gopc_pkg.sv
// package for the general output pin configuration bank
// assumes one 200 mhz clock domain; spi pins arrive unsynchronised
`default_nettype none
package gopc_pkg;

   // register addresses on the spi port
   localparam logic [5:0] GOPC_ADDR_PIN_B    = 6'h00;
   localparam logic [5:0] GOPC_ADDR_PIN_A    = 6'h01;
   localparam logic [5:0] GOPC_ADDR_CMD_LO   = 6'h30;
   localparam logic [5:0] GOPC_ADDR_CMD_HI   = 6'h3D;
   localparam logic [5:0] GOPC_ADDR_RX_FIFO  = 6'h3F;

   // header byte layout
   localparam int GOPC_HDR_RD_BIT    = 7;
   localparam int GOPC_HDR_BURST_BIT = 6;

   // config field positions
   localparam int GOPC_DS_BIT   = 7;
   localparam int GOPC_INV_BIT  = 6;
   localparam int GOPC_SEL_MSB  = 5;
   localparam int GOPC_SEL_W    = 6;

   // reset values
   localparam logic [7:0] GOPC_RST_PIN_B = 8'h29;
   localparam logic [7:0] GOPC_RST_PIN_A = 8'h2E;

   // select codes with fixed meaning
   localparam logic [5:0] GOPC_SEL_CHIP_READY = 6'h29;
   localparam logic [5:0] GOPC_SEL_HIZ        = 6'h2E;

   // command strobe positions in the strobe vector (address minus 0x30)
   localparam int GOPC_NUM_STROBES     = 14;
   localparam int GOPC_STB_RESET       = 0;
   localparam int GOPC_STB_OSC_OFF     = 2;
   localparam int GOPC_STB_CALIBRATE   = 3;
   localparam int GOPC_STB_RECEIVE     = 4;
   localparam int GOPC_STB_IDLE        = 6;
   localparam int GOPC_STB_POWER_DOWN  = 9;
   localparam int GOPC_STB_FLUSH_RX    = 10;
   localparam int GOPC_STB_NO_OP       = 13;

   // spi slave pins as seen by the device
   typedef struct packed {
      logic sclk;
      logic csn;
      logic mosi;
   } gopc_spi_in_t;

   // one general output pin: level plus active-low output enable
   typedef struct packed {
      logic level;
      logic oe_n;
   } gopc_pin_t;

   // whole state of the register bank and spi slave
   typedef struct packed {
      logic [2:0]  sclk_sy;
      logic [2:0]  csn_sy;
      logic [1:0]  mosi_sy;
      logic [2:0]  bitcnt;
      logic        hdr_done;
      logic        wr;
      logic        burst;
      logic [5:0]  addr;
      logic [7:0]  shin;
      logic [7:0]  shout;
      logic        miso;
      logic        miso_oe_n;
      logic [7:0]  cfg_a;
      logic [6:0]  cfg_b;
      logic [13:0] strobes;
      logic [5:0]  status_addr;
      logic        fifo_rd;
   } gopc_state_t;

endpackage
`default_nettype wire
